// ==== core/grch_top.sv ====
// Bus remote command handler: addressing, parser, control state, replies
`include "grch_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module grch_top (
  input  wire logic                CLK,
  input  wire logic                NRST,
  input  wire logic                RX_VALID,
  input  wire grch_pkg::grch_rx_t  RX_BYTE,
  output var  logic                TX_VALID,
  input  wire logic                TX_READY,
  output var  logic [7:0]          TX_DATA,
  input  wire grch_pkg::grch_pins_t PINS,
  input  wire logic                ADDR_SET_STB,
  input  wire logic [7:0]          ADDR_SET_VAL,
  output var  logic [4:0]          BUS_ADDR,
  output var  logic                DISP_LOCAL,
  output var  logic                DISP_BUS,
  output var  logic                RF_OPERATE,
  output var  logic                FAULT_LATCHED,
  output var  logic                SRQ,
  output var  logic                LISTENER,
  output var  logic                TALKER
);
  import grch_pkg::*;

  localparam logic [63:0] CMD_TXT [8] = '{
    `GRCH_TXT_REMOTE, `GRCH_TXT_LOCAL, `GRCH_TXT_OPERATE,
    `GRCH_TXT_STANDBY, `GRCH_TXT_RFQ, `GRCH_TXT_IDN,
    `GRCH_TXT_RST, `GRCH_TXT_CTRLQ};
  localparam logic [3:0] CMD_LEN [8] = '{
    `GRCH_LEN_REMOTE, `GRCH_LEN_LOCAL, `GRCH_LEN_OPERATE,
    `GRCH_LEN_STANDBY, `GRCH_LEN_RFQ, `GRCH_LEN_IDN,
    `GRCH_LEN_RST, `GRCH_LEN_CTRLQ};

  // ==========================================================
  // State
  logic [4:0]  addr_q;
  logic        listen_q;
  logic        talk_q;
  logic        remote_q;
  logic        rf_q;
  logic        fault_q;
  logic [7:0]  match_q;
  logic [3:0]  pos_q;
  logic        in_line_q;
  logic [63:0] resp_q;
  logic [3:0]  resp_len_q;
  logic        resp_pend_q;
  logic [2:0]  idx_q;
  grch_tx_st_t tx_st_q;
  grch_tx_st_t tx_st_d;
  grch_pins_t  pins_s;
  logic        ctrl_prev_q;
  logic        oper_prev_q;

  // ==========================================================
  // Pin synchronisation and key edges
  grch_sync #(.W(3)) u_sync (
    .CLK  (CLK),
    .NRST (NRST),
    .din  (PINS),
    .dout (pins_s)
  );

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_prev_q <= 1'b0;
      oper_prev_q <= 1'b0;
    end else begin
      ctrl_prev_q <= pins_s.ctrl_key;
      oper_prev_q <= pins_s.oper_key;
    end
  end

  wire ctrl_press = pins_s.ctrl_key & ~ctrl_prev_q;
  wire oper_press = pins_s.oper_key & ~oper_prev_q;

  // ==========================================================
  // Byte classification
  wire [6:0] rx_char = RX_BYTE.data[6:0];                 // R14
  wire is_if  = RX_VALID & ~RX_BYTE.atn_n;                // R09
  wire is_dev = RX_VALID & RX_BYTE.atn_n & listen_q;      // R14 R12
  wire [6:0] my_lad = `GRCH_LISTEN_BASE | {2'b00, addr_q}; // R18
  wire [6:0] my_tad = `GRCH_TALK_BASE | {2'b00, addr_q};   // R18
  wire dcl_w   = is_if & (rx_char == `GRCH_CODE_DCL);      // R10
  wire sdc_w   = is_if & listen_q & (rx_char == `GRCH_CODE_SDC); // R12
  wire gtl_w   = is_if & listen_q & (rx_char == `GRCH_CODE_GTL); // R12
  wire lad_w   = is_if & (rx_char == my_lad);
  wire unl_w   = is_if & (rx_char == `GRCH_CODE_UNL);      // R18
  wire tad_w   = is_if & (rx_char == my_tad);
  wire untad_w = is_if & (rx_char[6:5] == 2'b10) & ~tad_w;
  wire clr_w   = dcl_w | sdc_w;                            // R11
  wire eol_w   = is_dev & (rx_char == `GRCH_CHAR_LF);      // R15
  wire chr_w   = is_dev & (rx_char != `GRCH_CHAR_LF);
  wire new_w   = is_dev & ~in_line_q;                      // R19

  // ==========================================================
  // Addressing
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      listen_q <= 1'b0;
      talk_q   <= 1'b0;
    end else begin
      if (lad_w) begin
        listen_q <= 1'b1;
      end else if (unl_w) begin
        listen_q <= 1'b0;                                  // R13
      end
      if (tad_w) begin
        talk_q <= 1'b1;
      end else if (untad_w) begin
        talk_q <= 1'b0;
      end
    end
  end

  wire addr_ok = ADDR_SET_STB & (ADDR_SET_VAL >= `GRCH_ADDR_MIN)
                 & (ADDR_SET_VAL <= `GRCH_ADDR_MAX);       // R06

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      addr_q <= `GRCH_ADDR_DEFAULT;                        // R08
    end else if (addr_ok) begin
      addr_q <= ADDR_SET_VAL[4:0];                         // R07
    end
  end

  // ==========================================================
  // Command text matcher, one comparator per command string
  wire [7:0] hit_w;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_cmd
      wire [7:0] exp_c = CMD_TXT[i][8*(7-pos_q[2:0]) +: 8];
      wire       step  = match_q[i] & (pos_q < CMD_LEN[i])
                         & (exp_c == {1'b0, rx_char});
      assign hit_w[i] = eol_w & match_q[i] & (pos_q == CMD_LEN[i]); // R17
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          match_q[i] <= 1'b1;
        end else if (clr_w | eol_w) begin
          match_q[i] <= 1'b1;                              // R11
        end else if (chr_w) begin
          match_q[i] <= step;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pos_q     <= 4'h0;
      in_line_q <= 1'b0;
    end else if (clr_w | eol_w) begin
      pos_q     <= 4'h0;                                   // R11 R15
      in_line_q <= 1'b0;
    end else if (chr_w) begin
      pos_q     <= (pos_q == 4'hf) ? pos_q : pos_q + 4'h1; // R16
      in_line_q <= 1'b1;
    end
  end

  // ==========================================================
  // Control source, RF stage and fault
  wire to_remote = hit_w[GRCH_C_REMOTE];                   // R02
  wire to_local  = hit_w[GRCH_C_LOCAL] | gtl_w | ctrl_press; // R05
  wire rst_hit   = hit_w[GRCH_C_RST];
  wire rf_on  = ~fault_q & ((remote_q & hit_w[GRCH_C_OPERATE])
                | (~remote_q & oper_press & ~rf_q));
  wire rf_off = fault_q | rst_hit | (remote_q & hit_w[GRCH_C_STANDBY])
                | (~remote_q & oper_press & rf_q);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      remote_q <= 1'b0;                                    // R01
      rf_q     <= 1'b0;
      fault_q  <= 1'b0;
    end else begin
      if (!rf_q) begin                                     // R04
        if (to_remote) begin
          remote_q <= 1'b1;
        end else if (to_local) begin
          remote_q <= 1'b0;
        end
      end
      if (rf_off) begin
        rf_q <= 1'b0;
      end else if (rf_on) begin
        rf_q <= 1'b1;
      end
      if (pins_s.fault) begin
        fault_q <= 1'b1;                                   // R21
      end else if (rst_hit) begin
        fault_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Reply preparation
  wire q_rf   = hit_w[GRCH_C_RFQ];
  wire q_idn  = hit_w[GRCH_C_IDN];
  wire q_ctrl = hit_w[GRCH_C_CTRLQ];
  wire [63:0] rf_txt = rf_q ? `GRCH_TXT_OPERATE : `GRCH_TXT_STANDBY; // R20
  wire [3:0]  rf_len = rf_q ? `GRCH_LEN_OPERATE : `GRCH_LEN_STANDBY;
  wire [63:0] ct_txt = remote_q ? `GRCH_TXT_BUS : `GRCH_TXT_LOCAL;
  wire [3:0]  ct_len = remote_q ? `GRCH_LEN_BUS : `GRCH_LEN_LOCAL;
  wire [63:0] rep_txt = q_rf ? rf_txt : (q_idn ? `GRCH_TXT_ID : ct_txt);
  wire [3:0]  rep_len = q_rf ? rf_len : (q_idn ? `GRCH_LEN_ID : ct_len);
  wire        rep_w   = q_rf | q_idn | q_ctrl;

  // ==========================================================
  // Reply emitter into the output buffer
  logic       fifo_ready;
  logic       fifo_ovalid;
  logic [7:0] fifo_odata;
  wire        st_text  = (tx_st_q == GRCH_TX_TEXT);
  wire        st_term  = (tx_st_q == GRCH_TX_TERM);
  wire        push_w   = (st_text | st_term) & talk_q & fifo_ready;
  wire [7:0]  push_dat = st_term ? {1'b0, `GRCH_CHAR_LF}
                         : resp_q[8*(7-idx_q) +: 8];
  wire        last_chr = ({1'b0, idx_q} == resp_len_q - 4'h1);

  always_comb begin
    tx_st_d = tx_st_q;
    case (tx_st_q)
      GRCH_TX_IDLE: begin
        if (resp_pend_q & talk_q) begin
          tx_st_d = GRCH_TX_TEXT;                          // R19
        end
      end
      GRCH_TX_TEXT: begin
        if (push_w & last_chr) begin
          tx_st_d = GRCH_TX_TERM;
        end
      end
      GRCH_TX_TERM: begin
        if (push_w) begin
          tx_st_d = GRCH_TX_IDLE;
        end
      end
      default: tx_st_d = GRCH_TX_IDLE;
    endcase
    if (new_w) begin
      tx_st_d = GRCH_TX_IDLE;                              // R19
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tx_st_q <= GRCH_TX_IDLE;
    end else begin
      tx_st_q <= tx_st_d;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      resp_q      <= 64'h0;
      resp_len_q  <= 4'h1;
      resp_pend_q <= 1'b0;
      idx_q       <= 3'h0;
    end else if (rep_w) begin
      resp_q      <= rep_txt;
      resp_len_q  <= rep_len;
      resp_pend_q <= 1'b1;
      idx_q       <= 3'h0;
    end else if (new_w | (st_term & push_w)) begin
      resp_pend_q <= 1'b0;                                 // R19
      idx_q       <= 3'h0;
    end else if (st_text & push_w) begin
      idx_q       <= idx_q + 3'h1;
    end
  end

  grch_fifo2 u_buf (
    .CLK       (CLK),
    .NRST      (NRST),
    .flush     (new_w),
    .in_valid  ((st_text | st_term) & talk_q),
    .in_ready  (fifo_ready),
    .in_data   (push_dat),
    .out_valid (fifo_ovalid),
    .out_ready (TX_READY & talk_q),
    .out_data  (fifo_odata)
  );

  // ==========================================================
  // Outputs
  assign TX_VALID      = fifo_ovalid & talk_q;             // R19
  assign TX_DATA       = fifo_odata;
  assign BUS_ADDR      = addr_q;
  assign DISP_LOCAL    = ~remote_q;                        // R01
  assign DISP_BUS      = remote_q;                         // R03
  assign RF_OPERATE    = rf_q;
  assign FAULT_LATCHED = fault_q;
  assign SRQ           = fault_q;                          // R21
  assign LISTENER      = listen_q;
  assign TALKER        = talk_q;

  // ==========================================================
  // Checks
  sequence s_remote_line;
    to_remote && !rf_q;
  endsequence

  sequence s_clear;
    dcl_w || (sdc_w && listen_q);
  endsequence

  chk_local_start: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(NRST) |-> DISP_LOCAL && !DISP_BUS)               // R01
    else $error("not local after reset");

  chk_remote_entry: assert property (@(posedge CLK) disable iff (!NRST)
    s_remote_line |=> DISP_BUS [*2])                       // R02
    else $error("remote command not taken");

  chk_disp_excl: assert property (@(posedge CLK) disable iff (!NRST)
    DISP_BUS != DISP_LOCAL)                                // R03
    else $error("display indications clash");

  chk_mode_lock: assert property (@(posedge CLK) disable iff (!NRST)
    rf_q |=> $stable(remote_q))                            // R04
    else $error("control source changed in operate");

  chk_gtl_local: assert property (@(posedge CLK) disable iff (!NRST)
    (gtl_w && !rf_q && !to_remote) |=> !remote_q)          // R05
    else $error("go to local ignored");

  chk_addr_range: assert property (@(posedge CLK) disable iff (!NRST)
    BUS_ADDR >= 5'h01)                                     // R06
    else $error("bus address out of range");

  chk_addr_take: assert property (@(posedge CLK) disable iff (!NRST)
    addr_ok |=> {3'h0, BUS_ADDR} == $past(ADDR_SET_VAL))   // R07
    else $error("address not taken at once");

  chk_clear_parser: assert property (@(posedge CLK) disable iff (!NRST)
    s_clear |=> pos_q == 4'h0 && !in_line_q && &match_q
                && $stable(rf_q))                          // R11
    else $error("device clear did not reset parser");

  chk_listen_hold: assert property (@(posedge CLK) disable iff (!NRST)
    (listen_q && !unl_w) |=> listen_q)                     // R13
    else $error("listener dropped without unlisten");

  chk_fault_latch: assert property (@(posedge CLK) disable iff (!NRST)
    (fault_q && !rst_hit) |=> SRQ)                         // R21
    else $error("fault latch released early");

  chk_tx_hold: assert property (@(posedge CLK) disable iff (!NRST) // R19
    (TX_VALID && !TX_READY && !new_w && !untad_w)
    |=> TX_VALID && $stable(TX_DATA))
    else $error("reply byte dropped before taken");

  chk_reply_clear: assert property (@(posedge CLK) disable iff (!NRST)
    (new_w && !rep_w) |=> !resp_pend_q && !TX_VALID)       // R19
    else $error("new line did not clear reply");
endmodule
`default_nettype wire

// ==== include/grch_cfg.svh ====
// Constants of the bus remote command handler
// How it works
// [R01] After reset the control state is local and the local indication shows.
// [R02] A complete remote command line from a listener sets the remote state.
// [R03] In the remote state the bus-remote indication is shown.
// [R04] Local/remote changes are accepted only while the RF stage is standby.
// [R05] Go To Local or the front-panel control key returns to local.
// [R06] Address settings outside 01 to 31 are ignored.
// [R07] An accepted address setting is used from the next clock on.
// [R08] The bus address resets to 07.
// [R09] Bytes received with attention low are interface messages.
// [R10] Device clear to all acts whether or not the device is addressed.
// [R11] Device clear drops partial command text; settings stay as they were.
// [R12] Selected clear, go-to-local and command text need the listen address.
// [R13] The listen address holds until unlisten arrives.
// [R14] Bytes with attention high are 7-bit command text.
// [R15] Line feed is the only command terminator.
// [R16] Command lines have no length limit; only line feed ends them.
// [R17] Eight command strings are recognised and each acts or prepares a reply.
// [R18] Listen address is 32 plus address, talk 64 plus address, 63 unlisten.
// [R19] Replies go out when talk-addressed; a new command line clears them.
// [R20] The RF state query answers operate or standby text ended by line feed.
// [R21] A fault raises service request and stays latched until reset command.
`ifndef GRCH_CFG_SVH
`define GRCH_CFG_SVH

// ==========================================================
// Bus address
`define GRCH_ADDR_DEFAULT 5'h07
`define GRCH_ADDR_MIN     8'h01
`define GRCH_ADDR_MAX     8'h1f

// ==========================================================
// Interface message codes (7-bit)
`define GRCH_CODE_GTL     7'h01
`define GRCH_CODE_SDC     7'h04
`define GRCH_CODE_DCL     7'h14
`define GRCH_LISTEN_BASE  7'h20
`define GRCH_CODE_UNL     7'h3f
`define GRCH_TALK_BASE    7'h40
`define GRCH_CHAR_LF      7'h0a

// ==========================================================
// Command and reply text, first character in the top byte
`define GRCH_TXT_REMOTE   64'h52454d4f54450000
`define GRCH_TXT_LOCAL    64'h4c4f43414c000000
`define GRCH_TXT_OPERATE  64'h414d505f4f4e0000
`define GRCH_TXT_STANDBY  64'h414d505f4f464600
`define GRCH_TXT_RFQ      64'h414d503f00000000
`define GRCH_TXT_IDN      64'h2a49444e3f000000
`define GRCH_TXT_RST      64'h2a52535400000000
`define GRCH_TXT_CTRLQ    64'h434f4e54524f4c3f
`define GRCH_TXT_BUS      64'h4750494200000000
`define GRCH_LEN_REMOTE   4'h6
`define GRCH_LEN_LOCAL    4'h5
`define GRCH_LEN_OPERATE  4'h6
`define GRCH_LEN_STANDBY  4'h7
`define GRCH_LEN_RFQ      4'h4
`define GRCH_LEN_IDN      4'h5
`define GRCH_LEN_RST      4'h4
`define GRCH_LEN_CTRLQ    4'h8
`define GRCH_LEN_BUS      4'h4
// Identity reply text, arbitrary neutral value
`define GRCH_TXT_ID       64'h4445562c312c3000
`define GRCH_LEN_ID       4'h7

`endif

// ==== include/grch_pkg.sv ====
// Types of the bus remote command handler
package grch_pkg;

  typedef struct packed {
    logic       atn_n;
    logic [7:0] data;
  } grch_rx_t;

  typedef struct packed {
    logic ctrl_key;
    logic oper_key;
    logic fault;
  } grch_pins_t;

  typedef enum logic [2:0] {
    GRCH_C_REMOTE  = 3'h0,
    GRCH_C_LOCAL   = 3'h1,
    GRCH_C_OPERATE = 3'h2,
    GRCH_C_STANDBY = 3'h3,
    GRCH_C_RFQ     = 3'h4,
    GRCH_C_IDN     = 3'h5,
    GRCH_C_RST     = 3'h6,
    GRCH_C_CTRLQ   = 3'h7
  } grch_cmd_t;

  typedef enum logic [2:0] {
    GRCH_TX_IDLE = 3'b001,
    GRCH_TX_TEXT = 3'b010,
    GRCH_TX_TERM = 3'b100
  } grch_tx_st_t;

endpackage

// ==== core/grch_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module grch_sync #(
  parameter int W = 3
) (
  input  wire logic         CLK,
  input  wire logic         NRST,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          meta_q[i] <= 1'b0;
          dout[i]   <= 1'b0;
        end else begin
          meta_q[i] <= din[i];
          dout[i]   <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== core/grch_fifo2.sv ====
// Two-entry byte buffer with valid/ready on both sides and flush
`timescale 1ns/1ps
`default_nettype none
module grch_fifo2 (
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic       flush,
  input  wire logic       in_valid,
  output var  logic       in_ready,
  input  wire logic [7:0] in_data,
  output var  logic       out_valid,
  input  wire logic       out_ready,
  output var  logic [7:0] out_data
);
  logic [7:0] mem_q [2];
  logic       wp_q;
  logic       rp_q;
  logic [1:0] cnt_q;
  wire        push = in_valid & in_ready;
  wire        pop  = out_valid & out_ready;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else if (flush) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q  <= wp_q ^ push;
      rp_q  <= rp_q ^ pop;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge CLK) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ==== tb/grch_ctlr_model.sv ====
// Bus controller model: sends bus bytes and reads replies
`timescale 1ns/1ps
`default_nettype none
module grch_ctlr_model (
  input  wire logic               clk,
  input  wire logic               slow,
  output var  logic               rx_valid,
  output var  grch_pkg::grch_rx_t rx_byte,
  input  wire logic               tx_valid,
  output var  logic               tx_ready,
  input  wire logic [7:0]         tx_data
);
  import grch_pkg::*;
  logic [7:0] got_q [$];
  logic [1:0] cnt_q;
  initial begin
    rx_valid = 1'b0;
    rx_byte  = '{1'b1, 8'h55};
    tx_ready = 1'b0;
    cnt_q    = 2'h0;
  end
  // ==========================================================
  // Sender: n characters from the top byte, then line feed if lf is set
  task automatic send(input logic atn_n, input logic [63:0] txt,
                      input int n, input logic lf);
    int i;
    @(posedge clk);
    #1;
    rx_valid = 1'b1;
    for (i = 0; i < n + int'(lf); i++) begin
      rx_byte.atn_n = atn_n;
      rx_byte.data  = (i < n) ? {1'b0, txt[62-8*i -: 7]} : 8'h0a;
      @(posedge clk);
      #1;
    end
    rx_valid = 1'b0;
    rx_byte  = '{1'b1, ~rx_byte.data};
  endtask
  // ==========================================================
  // Reader: in slow mode takes one byte in four cycles
  always @(posedge clk) begin
    if (tx_valid && tx_ready)
      got_q.push_back(tx_data);
    cnt_q <= cnt_q + 2'h1;
    tx_ready <= #1 !slow || cnt_q == 2'h3;
  end
endmodule
`default_nettype wire

// ==== tb/test_gpib_remote_command_handler.sv ====
// Testbench of the bus remote command handler
`include "grch_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_gpib_remote_command_handler;
  import grch_pkg::*;
  logic       clk, nrst, rx_valid, tx_valid, tx_ready, set_stb, slow;
  grch_rx_t   rx_byte;
  grch_pins_t pins;
  logic [7:0] tx_data, set_val;
  logic [4:0] bus_addr;
  logic       disp_local, disp_bus, rf_op, fault_q, srq, listener, talker;
  int         err_count, compares;
  grch_top grch_top_i (.CLK(clk), .NRST(nrst), .RX_VALID(rx_valid),
    .RX_BYTE(rx_byte), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .TX_DATA(tx_data), .PINS(pins), .ADDR_SET_STB(set_stb),
    .ADDR_SET_VAL(set_val), .BUS_ADDR(bus_addr), .DISP_LOCAL(disp_local),
    .DISP_BUS(disp_bus), .RF_OPERATE(rf_op), .FAULT_LATCHED(fault_q),
    .SRQ(srq), .LISTENER(listener), .TALKER(talker));
  grch_ctlr_model grch_ctlr_model_i (.clk(clk), .slow(slow),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data));
  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic ifm(input logic [7:0] c);
    grch_ctlr_model_i.send(1'b0, {c, 56'h0}, 1, 1'b0);
  endtask
  task automatic line(input logic [63:0] t, input int n);
    grch_ctlr_model_i.send(1'b1, t, n, 1'b1);
  endtask
  task automatic pin(input int b, input logic v);
    @(posedge clk);
    #1;
    pins[b] = v;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic set_addr(input logic [7:0] v);
    @(posedge clk);
    #1;
    set_stb = 1'b1;
    set_val = v;
    @(posedge clk);
    #1;
    set_stb = 1'b0;
  endtask
  task automatic ask(input logic [63:0] q, input int qn,
                     input logic [63:0] r, input int rn);
    int i;
    ifm(8'h5f);
    grch_ctlr_model_i.got_q.delete();
    line(q, qn);
    ifm(8'h47);
    chk("talker", 8'h1, talker);
    for (i = 0; i < 200 && grch_ctlr_model_i.got_q.size() <= rn; i++) begin
      @(posedge clk);
      #1;
    end
    chk("reply length", 8'(rn + 1), 8'(grch_ctlr_model_i.got_q.size()));
    for (i = 0; i < grch_ctlr_model_i.got_q.size() && i <= rn; i++)
      chk("reply byte", i < rn ? r[63-8*i -: 8] : 8'h0a,
          grch_ctlr_model_i.got_q[i]);
  endtask
  task automatic results();
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("disp_local", 8'h1, disp_local);
    chk("disp_bus", 8'h0, disp_bus);
    chk("bus_addr", 8'h07, bus_addr);
    chk("listener", 8'h0, listener);
    chk("talker", 8'h0, talker);
  endtask
  task automatic t_remote();
    line(`GRCH_TXT_REMOTE, `GRCH_LEN_REMOTE);
    chk("unaddressed text", 8'h0, disp_bus);
    ifm(8'h27);
    chk("listener", 8'h1, listener);
    line(`GRCH_TXT_REMOTE | 64'h0000_0000_0000_0d00, 7);
    chk("cr ended line", 8'h0, disp_bus);
    line(`GRCH_TXT_REMOTE, `GRCH_LEN_REMOTE);
    chk("disp_bus", 8'h1, disp_bus);
    chk("disp_local", 8'h0, disp_local);
    chk("listener held", 8'h1, listener);
  endtask
  task automatic t_ctrl();
    line(`GRCH_TXT_OPERATE, `GRCH_LEN_OPERATE);
    chk("operate", 8'h1, rf_op);
    line(`GRCH_TXT_LOCAL, `GRCH_LEN_LOCAL);
    chk("local in operate", 8'h1, disp_bus);
    ifm(`GRCH_CODE_GTL);
    chk("gtl in operate", 8'h1, disp_bus);
    pin(2, 1'b1);
    pin(2, 1'b0);
    chk("key in operate", 8'h1, disp_bus);
    line(`GRCH_TXT_STANDBY, `GRCH_LEN_STANDBY);
    chk("standby", 8'h0, rf_op);
    ifm(`GRCH_CODE_GTL);
    chk("gtl", 8'h1, disp_local);
    line(`GRCH_TXT_REMOTE, `GRCH_LEN_REMOTE);
    pin(2, 1'b1);
    pin(2, 1'b0);
    chk("control key", 8'h1, disp_local);
    line(`GRCH_TXT_REMOTE, `GRCH_LEN_REMOTE);
    line(`GRCH_TXT_LOCAL, `GRCH_LEN_LOCAL);
    chk("local text", 8'h1, disp_local);
    pin(1, 1'b1);
    chk("oper key on", 8'h1, rf_op);
    pin(1, 1'b0);
    pin(1, 1'b1);
    chk("oper key off", 8'h0, rf_op);
    pin(1, 1'b0);
  endtask
  task automatic t_addr();
    set_addr(8'h00);
    chk("addr 0", 8'h07, bus_addr);
    set_addr(8'h20);
    chk("addr 32", 8'h07, bus_addr);
    set_addr(8'h1f);
    chk("addr 31", 8'h1f, bus_addr);
    set_addr(8'h01);
    chk("addr 1", 8'h01, bus_addr);
    set_addr(8'h05);
    ifm(`GRCH_CODE_UNL);
    chk("unlisten", 8'h0, listener);
    ifm(8'h27);
    chk("old address", 8'h0, listener);
    ifm(8'h25);
    chk("new address", 8'h1, listener);
    set_addr(8'h07);
  endtask
  task automatic t_reply();
    slow = 1'b1;
    ask(`GRCH_TXT_RFQ, `GRCH_LEN_RFQ, `GRCH_TXT_STANDBY,
        `GRCH_LEN_STANDBY);
    ask(`GRCH_TXT_CTRLQ, `GRCH_LEN_CTRLQ, `GRCH_TXT_LOCAL,
        `GRCH_LEN_LOCAL);
    line(`GRCH_TXT_REMOTE, `GRCH_LEN_REMOTE);
    ask(`GRCH_TXT_CTRLQ, `GRCH_LEN_CTRLQ, `GRCH_TXT_BUS,
        `GRCH_LEN_BUS);
    line(`GRCH_TXT_LOCAL, `GRCH_LEN_LOCAL);
    ask(`GRCH_TXT_IDN, `GRCH_LEN_IDN, `GRCH_TXT_ID, `GRCH_LEN_ID);
    slow = 1'b0;
    ifm(8'h5f);
    grch_ctlr_model_i.got_q.delete();
    line(`GRCH_TXT_RFQ, `GRCH_LEN_RFQ);
    line(`GRCH_TXT_RST, `GRCH_LEN_RST);
    ifm(8'h47);
    repeat (20) @(posedge clk);
    chk("flushed", 8'h0, 8'(grch_ctlr_model_i.got_q.size()));
  endtask
  task automatic t_clear();
    grch_ctlr_model_i.send(1'b1, `GRCH_TXT_REMOTE, 3, 1'b0);
    ifm(`GRCH_CODE_UNL);
    ifm(`GRCH_CODE_DCL);
    ifm(8'h27);
    line(`GRCH_TXT_REMOTE << 24, 3);
    chk("dcl drop", 8'h0, disp_bus);
    grch_ctlr_model_i.send(1'b1, `GRCH_TXT_REMOTE, 3, 1'b0);
    ifm(`GRCH_CODE_SDC);
    line(`GRCH_TXT_REMOTE << 24, 3);
    chk("sdc drop", 8'h0, disp_bus);
    chk("addr kept", 8'h07, bus_addr);
  endtask
  task automatic t_fault();
    line(`GRCH_TXT_REMOTE, `GRCH_LEN_REMOTE);
    line(`GRCH_TXT_OPERATE, `GRCH_LEN_OPERATE);
    pin(0, 1'b1);
    chk("fault standby", 8'h0, rf_op);
    chk("srq", 8'h1, srq);
    pin(0, 1'b0);
    chk("fault latched", 8'h1, fault_q);
    line(`GRCH_TXT_OPERATE, `GRCH_LEN_OPERATE);
    chk("operate refused", 8'h0, rf_op);
    line(`GRCH_TXT_RST, `GRCH_LEN_RST);
    chk("fault cleared", 8'h0, fault_q);
    chk("srq cleared", 8'h0, srq);
    line(`GRCH_TXT_OPERATE, `GRCH_LEN_OPERATE);
    chk("operate again", 8'h1, rf_op);
  endtask
  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 20000);
    err_count++;
    results();
  end
  initial begin
    err_count = 0;
    compares  = 0;
    nrst      = 1'b0;
    pins      = '0;
    set_stb   = 1'b0;
    set_val   = 8'h00;
    slow      = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_remote();
    t_ctrl();
    t_addr();
    t_reply();
    t_clear();
    t_fault();
    results();
  end
endmodule
`default_nettype wire
